// ### hw/cpalu_pkg.sv
// Purpose: Shared constants and types for the arithmetic, logic and branch execution core
// Assumes: One clock, asynchronous active-low reset, one instruction request at a time
// Notes: Status bits follow the usual carry, zero, negative, overflow, sign, half, transfer, interrupt order
// Contract
// - Register add, optionally with carry, one cycle; updates Z, C, N, V, H.
// - Word add immediate on register pair, two cycles; updates Z, C, N, V, S.
// - Word subtract immediate on register pair, two cycles; updates Z, C, N, V, S.
// - Subtract constant from register, one cycle, write back; updates Z, C, N, V, H.
// - Register subtract with borrow also deducts carry, one cycle; five flags.
// - Constant subtract with borrow deducts constant and carry, one cycle; five flags.
// - AND, OR register or constant, XOR register only, one cycle; only Z, N, V change.
// - Clear mask ANDs with 0xFF minus constant; set mask ORs; Z, N, V only.
// - Zero-sign test ANDs register with itself, value unchanged; Z, N, V updated.
// - Zero register XORs itself, Z N V; fill loads 0xFF, no flags; one cycle.
// - 8x8 unsigned, signed, mixed multiply into pair one:zero, two cycles; Z, C.
// - Fractional multiply shifts product left one, pair one:zero, two cycles; Z, C.
// - Indirect jump loads PC from Z pointer, no flags, two cycles.
// - Indirect call saves return address, PC from Z, no flags, three cycles.
// - Compare-skip: no result stored; equal skips 1 or 2 words; 1/2/3 cycles.
package cpalu_pkg;
    localparam int          REG_COUNT  = 32;
    localparam int          OFFSET_W   = 12;
    localparam logic [4:0]  PROD_LO    = 5'h00;
    localparam logic [4:0]  Z_LO       = 5'h1e;
    localparam logic [4:0]  Z_HI       = 5'h1f;
    localparam logic [7:0]  ALL_ONES   = 8'hff;
    localparam logic [7:0]  SREG_RESET = 8'h00;
    localparam logic [5:0]  WORD_K_MASK = 6'h3f;
    localparam int          FLAG_C     = 0;
    localparam int          FLAG_Z     = 1;
    localparam int          FLAG_N     = 2;
    localparam int          FLAG_V     = 3;
    localparam int          FLAG_S     = 4;
    localparam int          FLAG_H     = 5;
    localparam int          FLAG_I     = 7;
    localparam logic [2:0]  CYC_ONE    = 3'h1;
    localparam logic [2:0]  CYC_TWO    = 3'h2;
    localparam logic [2:0]  CYC_THREE  = 3'h3;
    localparam logic [2:0]  CYC_FOUR   = 3'h4;

    typedef enum logic [4:0] {
        add_registers, add_with_carry, minus_registers, minus_constant, minus_with_borrow,
        minus_const_with_borrow, word_add_immediate, word_sub_immediate, and_registers,
        and_immediate, or_registers, or_immediate, xor_registers, set_mask_bits, clear_mask_bits,
        zero_sign_test, zero_register, fill_register, product_unsigned, product_signed,
        product_mixed_sign, frac_product_unsigned, frac_product_signed, frac_product_mixed,
        indirect_jump_pointer, indirect_subcall, relative_jump, relative_subcall, call_exit,
        irq_exit, compare_skip_equal
    } cpalu_op_type;

    typedef struct packed {
        cpalu_op_type          op;
        logic [4:0]            dst;
        logic [4:0]            src;
        logic [7:0]            imm;
        logic [OFFSET_W-1:0]   offset;
        logic                  skip_long;
    } cpalu_req_type;
endpackage

// ### hw/cpalu_core.sv
// Purpose: Executes one arithmetic, logic, multiply or branch instruction per request
// Assumes: Requests come from logic on the same clock; register loads only for setup
// Notes: Results land at the accepting edge; busy then holds for the remaining cycles
`timescale 1ns/1ps
module cpalu_core #(
    parameter int PC_W        = 16,
    parameter int STACK_DEPTH = 16
) (
    input  wire logic                    clock,
    input  wire logic                    arst_n,
    input  wire logic                    start,
    input  wire cpalu_pkg::cpalu_req_type req,
    input  wire logic                    load_valid,
    input  wire logic [4:0]              load_index,
    input  wire logic [7:0]              load_data,
    input  wire logic [4:0]              peek_index,
    output logic [7:0]                   peek_data,
    output logic                         busy,
    output logic                         done,
    output logic [PC_W-1:0]              pc,
    output logic [7:0]                   sreg
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    logic [7:0]      regs [cpalu_pkg::REG_COUNT];
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [2:0]      cnt;
    cpalu_pkg::cpalu_op_type op;
    logic [7:0]         a, rr_val, opnd, logic_res;
    logic [4:0]         dst_hi;
    logic               use_imm, carry_in, ext_a, ext_b, is_or, equal, accept;
    logic [8:0]         sum9, dif9;
    logic [15:0]        pair, wk, wsum, wdif, prod, zptr;
    logic signed [17:0] prod_full;
    logic [PC_W-1:0]    pc_inc, rel_target, stack_top;
    logic [7:0]         next_res, next_sreg;
    logic               next_wr_reg, next_wr_word, next_push, next_pop;
    logic [4:0]         next_word_lo;
    logic [15:0]        next_word;
    logic [PC_W-1:0]    next_pc;
    logic [2:0]         next_cyc;

    assign op       = req.op;
    assign accept   = start & ~busy;
    assign a        = regs[req.dst];
    assign rr_val   = regs[req.src];
    assign dst_hi   = 5'(req.dst + 5'h01);
    assign use_imm  = op inside {cpalu_pkg::minus_constant, cpalu_pkg::minus_const_with_borrow,
                                 cpalu_pkg::and_immediate, cpalu_pkg::or_immediate,
                                 cpalu_pkg::set_mask_bits, cpalu_pkg::clear_mask_bits};
    assign opnd     = (op == cpalu_pkg::clear_mask_bits) ? (cpalu_pkg::ALL_ONES - req.imm) :
                      use_imm ? req.imm : rr_val;
    assign carry_in = (op inside {cpalu_pkg::add_with_carry, cpalu_pkg::minus_with_borrow,
                                  cpalu_pkg::minus_const_with_borrow}) & sreg[cpalu_pkg::FLAG_C];
    assign sum9     = {1'b0, a} + {1'b0, opnd} + {8'h00, carry_in};
    assign dif9     = {1'b0, a} - {1'b0, opnd} - {8'h00, carry_in};
    assign pair     = {regs[dst_hi], a};
    assign wk       = {10'h000, req.imm[5:0] & cpalu_pkg::WORD_K_MASK};
    assign wsum     = pair + wk;
    assign wdif     = pair - wk;
    assign ext_a    = a[7] & (op inside {cpalu_pkg::product_signed, cpalu_pkg::product_mixed_sign,
                                         cpalu_pkg::frac_product_signed, cpalu_pkg::frac_product_mixed});
    assign ext_b    = rr_val[7] & (op inside {cpalu_pkg::product_signed, cpalu_pkg::frac_product_signed});
    assign is_or    = op inside {cpalu_pkg::or_registers, cpalu_pkg::or_immediate, cpalu_pkg::set_mask_bits};
    // Test and clear use the register alone
    assign logic_res = is_or ? (a | opnd) :
                       (op == cpalu_pkg::xor_registers) ? (a ^ opnd) :
                       (op == cpalu_pkg::zero_register) ? (a ^ a) :
                       (op == cpalu_pkg::zero_sign_test) ? (a & a) : (a & opnd);
    assign prod_full = $signed({ext_a, a}) * $signed({ext_b, rr_val});
    assign prod     = prod_full[15:0];
    assign zptr     = {regs[cpalu_pkg::Z_HI], regs[cpalu_pkg::Z_LO]};
    assign pc_inc   = PC_W'(pc + 1);
    assign rel_target = PC_W'(pc + {{(PC_W-cpalu_pkg::OFFSET_W){req.offset[cpalu_pkg::OFFSET_W-1]}},
                                    req.offset} + 1);
    assign stack_top = stack[SP_W'(sp - 1'b1)];
    assign equal    = (a == rr_val);

    always_comb begin
        next_res     = a;
        next_wr_reg  = 1'b0;
        next_wr_word = 1'b0;
        next_word_lo = req.dst;
        next_word    = pair;
        next_sreg    = sreg;
        next_pc      = pc_inc;
        next_cyc     = cpalu_pkg::CYC_ONE;
        next_push    = 1'b0;
        next_pop     = 1'b0;
        case (op)
            cpalu_pkg::add_registers, cpalu_pkg::add_with_carry: begin
                next_res    = sum9[7:0];
                next_wr_reg = 1'b1;
                next_sreg[cpalu_pkg::FLAG_C] = sum9[8];
                next_sreg[cpalu_pkg::FLAG_H] = (a[3] & opnd[3]) | (opnd[3] & ~sum9[3]) | (~sum9[3] & a[3]);
                next_sreg[cpalu_pkg::FLAG_V] = (a[7] & opnd[7] & ~sum9[7]) | (~a[7] & ~opnd[7] & sum9[7]);
                next_sreg[cpalu_pkg::FLAG_N] = sum9[7];
                next_sreg[cpalu_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
            end
            cpalu_pkg::minus_registers, cpalu_pkg::minus_constant, cpalu_pkg::minus_with_borrow,
            cpalu_pkg::minus_const_with_borrow: begin
                next_res    = dif9[7:0];
                next_wr_reg = 1'b1;
                next_sreg[cpalu_pkg::FLAG_C] = dif9[8];
                next_sreg[cpalu_pkg::FLAG_H] = (~a[3] & opnd[3]) | (opnd[3] & dif9[3]) | (dif9[3] & ~a[3]);
                next_sreg[cpalu_pkg::FLAG_V] = (a[7] & ~opnd[7] & ~dif9[7]) | (~a[7] & opnd[7] & dif9[7]);
                next_sreg[cpalu_pkg::FLAG_N] = dif9[7];
                next_sreg[cpalu_pkg::FLAG_Z] = (dif9[7:0] == 8'h00);
            end
            cpalu_pkg::word_add_immediate, cpalu_pkg::word_sub_immediate: begin
                next_wr_word = 1'b1;
                next_cyc     = cpalu_pkg::CYC_TWO;
                next_word    = (op == cpalu_pkg::word_add_immediate) ? wsum : wdif;
                next_sreg[cpalu_pkg::FLAG_V] = (op == cpalu_pkg::word_add_immediate) ?
                                               (~pair[15] & wsum[15]) : (pair[15] & ~wdif[15]);
                next_sreg[cpalu_pkg::FLAG_C] = (op == cpalu_pkg::word_add_immediate) ?
                                               (pair[15] & ~wsum[15]) : (~pair[15] & wdif[15]);
                next_sreg[cpalu_pkg::FLAG_N] = next_word[15];
                next_sreg[cpalu_pkg::FLAG_Z] = (next_word == 16'h0000);
                next_sreg[cpalu_pkg::FLAG_S] = next_word[15] ^ next_sreg[cpalu_pkg::FLAG_V];
            end
            cpalu_pkg::and_registers, cpalu_pkg::and_immediate, cpalu_pkg::clear_mask_bits,
            cpalu_pkg::zero_sign_test, cpalu_pkg::or_registers, cpalu_pkg::or_immediate,
            cpalu_pkg::set_mask_bits, cpalu_pkg::xor_registers, cpalu_pkg::zero_register: begin
                next_res = logic_res;
                next_wr_reg = 1'b1;
                next_sreg[cpalu_pkg::FLAG_V] = 1'b0;
                next_sreg[cpalu_pkg::FLAG_N] = next_res[7];
                next_sreg[cpalu_pkg::FLAG_Z] = (next_res == 8'h00);
            end
            cpalu_pkg::fill_register: begin
                next_res    = cpalu_pkg::ALL_ONES;
                next_wr_reg = 1'b1;
            end
            cpalu_pkg::product_unsigned, cpalu_pkg::product_signed, cpalu_pkg::product_mixed_sign,
            cpalu_pkg::frac_product_unsigned, cpalu_pkg::frac_product_signed,
            cpalu_pkg::frac_product_mixed: begin
                next_wr_word = 1'b1;
                next_word_lo = cpalu_pkg::PROD_LO;
                next_cyc     = cpalu_pkg::CYC_TWO;
                next_word    = (op inside {cpalu_pkg::product_unsigned, cpalu_pkg::product_signed,
                                           cpalu_pkg::product_mixed_sign}) ? prod : {prod[14:0], 1'b0};
                next_sreg[cpalu_pkg::FLAG_C] = prod[15];
                next_sreg[cpalu_pkg::FLAG_Z] = (next_word == 16'h0000);
            end
            cpalu_pkg::indirect_jump_pointer, cpalu_pkg::indirect_subcall: begin
                next_pc   = PC_W'(zptr);
                next_push = (op == cpalu_pkg::indirect_subcall);
                next_cyc  = next_push ? cpalu_pkg::CYC_THREE : cpalu_pkg::CYC_TWO;
            end
            cpalu_pkg::relative_jump, cpalu_pkg::relative_subcall: begin
                next_pc   = rel_target;
                next_push = (op == cpalu_pkg::relative_subcall);
                next_cyc  = next_push ? cpalu_pkg::CYC_THREE : cpalu_pkg::CYC_TWO;
            end
            cpalu_pkg::call_exit, cpalu_pkg::irq_exit: begin
                next_pc  = stack_top;
                next_pop = 1'b1;
                next_cyc = cpalu_pkg::CYC_FOUR;
                if (op == cpalu_pkg::irq_exit) begin
                    next_sreg[cpalu_pkg::FLAG_I] = 1'b1;
                end
            end
            // Skip next one or two words
            cpalu_pkg::compare_skip_equal: begin
                if (equal) begin
                    next_pc  = PC_W'(pc + (req.skip_long ? 3 : 2));
                    next_cyc = req.skip_long ? cpalu_pkg::CYC_THREE : cpalu_pkg::CYC_TWO;
                end
            end
            default: next_cyc = cpalu_pkg::CYC_ONE;
        endcase
    end

    // Register writes from an accepted instruction win over setup loads
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < cpalu_pkg::REG_COUNT; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (accept && next_wr_word) begin
            regs[next_word_lo]             <= next_word[7:0];
            regs[5'(next_word_lo + 5'h01)] <= next_word[15:8];
        end else if (accept && next_wr_reg) begin
            regs[req.dst] <= next_res;
        end else if (load_valid) begin
            regs[load_index] <= load_data;
        end
    end
    // Return stack wraps when overfilled; popping an empty stack returns stale data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= '0;
            end
        end else if (accept && next_push) begin
            stack[sp] <= pc_inc;
            sp        <= SP_W'(sp + 1'b1);
        end else if (accept && next_pop) begin
            sp <= SP_W'(sp - 1'b1);
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pc   <= '0;
            sreg <= cpalu_pkg::SREG_RESET;
        end else if (accept) begin
            pc   <= next_pc;
            sreg <= next_sreg;
        end
    end
    // Occupancy counter gives each instruction its cycle count
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (accept) begin
            cnt  <= 3'(next_cyc - 3'h1);
            busy <= (next_cyc != cpalu_pkg::CYC_ONE);
            done <= (next_cyc == cpalu_pkg::CYC_ONE);
        end else begin
            cnt  <= (cnt != 3'h0) ? 3'(cnt - 3'h1) : 3'h0;
            busy <= busy && (cnt != 3'h1);
            done <= busy && (cnt == 3'h1);
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            peek_data <= 8'h00;
        end else begin
            peek_data <= regs[peek_index];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence seq_two;
        busy ##1 done;
    endsequence
    sequence seq_three;
        busy [*2] ##1 done;
    endsequence
    sequence seq_four;
        busy [*3] ##1 done;
    endsequence
    chk_single_cycle_done: assert property (accept &&
        op inside {cpalu_pkg::add_registers, cpalu_pkg::add_with_carry} |=> done && !busy)
        else $error("one-cycle add did not finish in one cycle");
    chk_word_add_timing: assert property (accept && op == cpalu_pkg::word_add_immediate |=> seq_two)
        else $error("word add did not take two cycles");
    chk_word_sub_sign: assert property (accept && op == cpalu_pkg::word_sub_immediate |=>
        sreg[cpalu_pkg::FLAG_S] == (sreg[cpalu_pkg::FLAG_N] ^ sreg[cpalu_pkg::FLAG_V]) ##1 done)
        else $error("word subtract sign or timing wrong");
    chk_logic_keeps_carry: assert property (accept &&
        op inside {cpalu_pkg::and_registers, cpalu_pkg::or_immediate, cpalu_pkg::xor_registers} |=>
        sreg[cpalu_pkg::FLAG_C] == $past(sreg[cpalu_pkg::FLAG_C]) && !sreg[cpalu_pkg::FLAG_V])
        else $error("logic op disturbed carry or left overflow set");
    chk_fill_no_flags: assert property (accept && op == cpalu_pkg::fill_register |=>
        sreg == $past(sreg) && regs[$past(req.dst)] == cpalu_pkg::ALL_ONES)
        else $error("fill changed flags or value");
    chk_mul_carry_bit: assert property (accept && op == cpalu_pkg::product_unsigned |=>
        sreg[cpalu_pkg::FLAG_C] == $past(prod[15]) && regs[1] == $past(prod[15:8]) ##1 done)
        else $error("multiply carry or result wrong");
    chk_frac_shifted: assert property (accept && op == cpalu_pkg::frac_product_unsigned |=>
        regs[0] == {$past(prod[6:0]), 1'b0})
        else $error("fractional product not shifted");
    chk_indirect_jump_pointer_target: assert property (accept && op == cpalu_pkg::indirect_jump_pointer |=>
        pc == PC_W'($past(zptr)) && sreg == $past(sreg) ##1 done)
        else $error("indirect jump target or timing wrong");
    chk_call_timing: assert property (accept &&
        op inside {cpalu_pkg::indirect_subcall, cpalu_pkg::relative_subcall} |=> seq_three)
        else $error("call did not take three cycles");
    chk_skip_cycles: assert property (accept && op == cpalu_pkg::compare_skip_equal && equal && req.skip_long
        |=> pc == PC_W'($past(pc) + 3) ##0 seq_three)
        else $error("long skip wrong");
    chk_relative_jump_target: assert property (accept && op == cpalu_pkg::relative_jump |=> pc == $past(rel_target) ##0 seq_two)
        else $error("relative jump wrong");
    chk_irq_exit_enable: assert property (accept && op == cpalu_pkg::irq_exit |=>
        sreg[cpalu_pkg::FLAG_I] ##0 seq_four)
        else $error("interrupt return wrong");
endmodule

// ### testbench/cpalu_core_tb_top.sv
// Purpose: Self-checking bench for the arithmetic, logic and branch execution core
// Assumes: Default PC and stack sizes; results land at the accepting edge
// Notes: Byte, word and multiply operations meet random and boundary operands; branches are directed
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module cpalu_core_tb_top;
    logic                     clock = 1'b0;
    logic                     arst_n = 1'b0;
    logic                     start = 1'b0;
    cpalu_pkg::cpalu_req_type req = '0;
    logic                     load_valid = 1'b0;
    logic [4:0]               load_index = 5'h00;
    logic [7:0]               load_data = 8'h00;
    logic [4:0]               peek_index = 5'h00;
    logic [7:0]               peek_data;
    logic                     busy;
    logic                     done;
    logic [15:0]              pc;
    logic [7:0]               sreg;
    logic [7:0]               rf [32];
    logic [7:0]               es = 8'h00;
    logic [31:0]              seed = 32'h1a45_c20d;
    int                       errors = 0;
    int                       n_compared = 0;

    cpalu_core DUT (.clock(clock), .arst_n(arst_n), .start(start), .req(req), .load_valid(load_valid),
        .load_index(load_index), .load_data(load_data), .peek_index(peek_index), .peek_data(peek_data),
        .busy(busy), .done(done), .pc(pc), .sreg(sreg));

    always #4 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Half the operands are boundary bytes 00, 7f, 80, ff to reach overflow and carry edges
    function automatic logic [7:0] cv(input logic [31:0] x);
        return x[3] ? {x[1], {7{x[0]}}} : x[15:8];
    endfunction

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic ld(input logic [4:0] i, input logic [7:0] v);
        @(posedge clock);
        load_valid <= 1'b1;
        load_index <= i;
        load_data  <= v;
        @(posedge clock);
        load_valid <= 1'b0;
        rf[i] = v;
    endtask

    task automatic peek(input logic [4:0] i);
        @(posedge clock);
        peek_index <= i;
        repeat (2) @(posedge clock);
        #1;
        `CHK(peek_data, rf[i])
    endtask

    task automatic run(input logic [4:0] o, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k,
                       input logic [11:0] off, input logic lng, input logic [3:0] n);
        logic [3:0] c;
        @(posedge clock);
        start <= 1'b1;
        req   <= '{cpalu_pkg::cpalu_op_type'(o), d, s, k, off, lng};
        @(posedge clock);
        start <= 1'b0;
        c = 4'h1;
        #1;
        while (done !== 1'b1 && c < 4'hc) begin
            `CHK(busy, 1'b1)
            @(posedge clock);
            #1;
            c++;
        end
        `CHK(c, n)
        if (c == 4'hc) close_out();
    endtask

    task automatic br(input logic [4:0] o, input logic [11:0] off, input logic lng, input logic [3:0] n,
                      input logic [15:0] ep);
        run(o, 5'd5, 5'd6, 8'h00, off, lng, n);
        `CHK(pc, ep)
        `CHK(sreg, es)
    endtask

    // Op codes by enum position: 0-5 byte arithmetic, 6-7 word, 8-17 logic, 18-23 multiply
    function automatic void model(input logic [4:0] o, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k,
                                  output logic [3:0] n);
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  r;
        logic [8:0]  w9;
        logic [4:0]  h5;
        logic [15:0] w;
        logic [16:0] w17;
        logic [15:0] p;
        logic        ci;
        a = rf[d];
        b = (o inside {5'd3, 5'd5, 5'd9, 5'd11, 5'd13, 5'd14}) ? k : rf[s];
        ci = (o inside {5'd1, 5'd4, 5'd5}) ? es[0] : 1'b0;
        w = {rf[d + 5'd1], a};
        n = 4'h1;
        r = a;
        case (o) inside
            [5'd0:5'd1]: begin
                w9 = a + b + ci;
                h5 = a[3:0] + b[3:0] + ci;
                es[3] = (a[7] == b[7]) && (w9[7] != a[7]);
            end
            [5'd2:5'd5]: begin
                w9 = {1'b0, a} - b - ci;
                h5 = {1'b0, a[3:0]} - b[3:0] - ci;
                es[3] = (a[7] != b[7]) && (w9[7] != a[7]);
            end
            [5'd6:5'd7]: begin
                w17 = (o == 5'd6) ? w + k[5:0] : {1'b0, w} - k[5:0];
                es[3] = (o == 5'd6) ? (!w[15] && w17[15]) : (w[15] && !w17[15]);
                es[0] = w17[16];
                es[1] = (w17[15:0] == 16'h0000);
                es[2] = w17[15];
                es[4] = es[2] ^ es[3];
                {rf[d + 5'd1], rf[d]} = w17[15:0];
                n = 4'h2;
            end
            5'd8, 5'd9: r = a & b;
            5'd10, 5'd11, 5'd13: r = a | b;
            5'd12: r = a ^ b;
            5'd14: r = a & (8'hff - b);
            5'd16: r = 8'h00;
            5'd17: rf[d] = 8'hff;
            [5'd18:5'd23]: begin
                p = a * b;
                if (o == 5'd19 || o == 5'd22) p = $signed(a) * $signed(b);
                if (o == 5'd20 || o == 5'd23) p = $signed(a) * $signed({1'b0, b});
                es[0] = p[15];
                if (o > 5'd20) p = p << 1;
                es[1] = (p == 16'h0000);
                {rf[1], rf[0]} = p;
                n = 4'h2;
            end
            default: n = 4'h1;
        endcase
        if (o < 5'd6) begin
            r = w9[7:0];
            es[0] = w9[8];
            es[5] = h5[4];
        end
        if (o > 5'd7 && o < 5'd17) es[3] = 1'b0;
        if (o < 5'd6 || (o > 5'd7 && o < 5'd17)) begin
            es[1] = (r == 8'h00);
            es[2] = r[7];
            rf[d] = r;
        end
    endfunction

    initial begin
        logic [4:0] o;
        logic [4:0] d;
        logic [4:0] s;
        logic [7:0] k;
        logic [3:0] n;
        for (int i = 0; i < 32; i++) rf[i] = 8'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        #1;
        `CHK(pc, 16'h0000)
        `CHK(sreg, 8'h00)
        for (int i = 0; i < 96; i++) begin
            seed = xs(seed);
            o = 5'(i % 24);
            d = 5'd2 + (seed[4:0] % 5'd26);
            s = seed[9:5];
            k = seed[31:24];
            ld(d, cv(seed));
            seed = xs(seed);
            ld(s, cv(seed));
            seed = xs(seed);
            ld(d + 5'd1, cv(seed));
            model(o, d, s, k, n);
            run(o, d, s, k, 12'h000, 1'b0, n);
            `CHK(sreg, es)
            peek(d);
            peek(d + 5'd1);
            peek(5'd0);
            peek(5'd1);
        end
        ld(5'd30, 8'h34);
        ld(5'd31, 8'h12);
        br(5'd24, 12'h000, 1'b0, 4'h2, 16'h1234);
        br(5'd27, 12'hffe, 1'b0, 4'h3, 16'h1233);
        br(5'd26, 12'h7ff, 1'b0, 4'h2, 16'h1a33);
        br(5'd25, 12'h000, 1'b0, 4'h3, 16'h1234);
        br(5'd28, 12'h000, 1'b0, 4'h4, 16'h1a34);
        es[7] = 1'b1;
        br(5'd29, 12'h000, 1'b0, 4'h4, 16'h1235);
        ld(5'd5, 8'h5a);
        ld(5'd6, 8'h5a);
        br(5'd30, 12'h000, 1'b0, 4'h2, 16'h1237);
        br(5'd30, 12'h000, 1'b1, 4'h3, 16'h123a);
        ld(5'd6, 8'h5b);
        br(5'd30, 12'h000, 1'b1, 4'h1, 16'h123b);
        peek(5'd5);
        close_out();
    end
endmodule
